// *** hw/pt_pkg.sv ***
package pt_pkg;
  // clock and control-cycle timing
  localparam int PT_CLK_NS = 4;
  localparam int PT_CYCLE_NS = 1000;
  localparam int PT_TICK_CYCLES = (PT_CYCLE_NS + PT_CLK_NS - 1) / PT_CLK_NS;

  // wrap points of the low total word
  localparam logic [16:0] PT_BIN_MOD = 17'h08000;
  localparam logic [16:0] PT_DEC_MOD = 17'h02710;
  // engineering-unit span and unity scaling factor (unsigned 8.8 fixed point)
  localparam logic [15:0] PT_EU_SPAN = 16'h2710;
  localparam logic [15:0] PT_FACTOR_ONE = 16'h0100;
  localparam int PT_FACTOR_FRAC = 8;

  // register byte offsets
  localparam logic [11:0] PT_OFF_CSW = 12'h000;
  localparam logic [11:0] PT_OFF_UPPER = 12'h004;
  localparam logic [11:0] PT_OFF_LOWER = 12'h008;
  localparam logic [11:0] PT_OFF_WINDOW = 12'h00c;
  localparam logic [11:0] PT_OFF_SUM = 12'h010;
  localparam logic [11:0] PT_OFF_SAVED = 12'h014;
  localparam logic [11:0] PT_OFF_WCOUNT = 12'h018;
  localparam logic [11:0] PT_OFF_IRQ_STAT = 12'h01c;
  localparam logic [11:0] PT_OFF_IRQ_MASK = 12'h020;
  localparam logic [11:0] PT_OFF_CH_TRIP = 12'h040;
  localparam logic [11:0] PT_OFF_CH_FACTOR = 12'h050;
  localparam logic [11:0] PT_OFF_CH_FLOW = 12'h060;
  localparam logic [11:0] PT_OFF_CH_SUM = 12'h070;
  localparam logic [11:0] PT_OFF_CH_SAVED = 12'h080;

  // control/status word fields
  localparam int PT_CSW_RUN = 0;
  localparam int PT_CSW_CLR = 1;
  localparam int PT_CSW_OK = 2;
  localparam int PT_CSW_FLAG = 3;
  localparam int PT_CSW_MODE = 8;

  // interrupt status bits
  localparam int PT_IRQ_WIN = 0;
  localparam int PT_IRQ_FLAG = 1;
  localparam int PT_IRQ_STORE = 2;
  localparam int PT_IRQ_W = 3;

  // reset values
  localparam logic PT_MODE_RST = 1'b1;
  localparam logic [15:0] PT_TRIP_RST = 16'h0000;
  localparam logic [15:0] PT_WINDOW_RST = 16'h0001;

  // apb request and answer carriers
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pt_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pt_apb_rsp_t;

  typedef logic [3:0][15:0] pt_quad_t;
endpackage

// *** hw/pt_wrap_add.sv ***
`timescale 1ns/1ps
// adds one cycle's pulses to a low/high pair, wrapping the low word
module pt_wrap_add
  import pt_pkg::*;
(
  input wire logic [15:0] i_low,
  input wire logic [15:0] i_high,
  input wire logic [15:0] i_add,
  input wire logic i_binary,
  output logic [15:0] o_low,
  output logic [15:0] o_high
);
  logic [16:0] sum; // low word plus new pulses, may hold several wraps worth
  logic [16:0] modv; // wrap point for the chosen mode
  logic [16:0] quo;
  logic [16:0] rem;

  // a large pulse count may wrap the low word more than once, so divide
  always_comb begin
    sum = {1'b0, i_low} + {1'b0, i_add};
    modv = i_binary ? PT_BIN_MOD : PT_DEC_MOD;
    quo = sum / modv;
    rem = sum % modv;
    o_low = rem[15:0];
    o_high = i_high + quo[15:0];
  end
endmodule

// *** hw/pt_pulse_totalizer.sv ***
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ps
// How it works
// - add each cycle's pulse count to totals
// - store-and-zero saves totals then clears them
// - binary mode wraps low word past 32767
// - decimal mode wraps low word past 9999
// - control word bit 8 selects mode
// - saved words share the wrap mode
// - window count updated at each window end
// - flow flag hysteresis on upper/lower levels
// - status bits show run, clear, ok, flag
// - four channels totalize, save, zero, continue
// - per-channel factor, unity spans 0..10000
// - channel flag above upper, clear at lower
// - channel flow is factor-scaled pulses per window
// - not running: no execution, outputs zero except fetch strobe, irq and apb reads
// - channel save on clear rising edge
module pt_pulse_totalizer
  import pt_pkg::*;
#(
  parameter int TICK_CYCLES = PT_TICK_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_run, // run request pin
  input wire logic i_store_and_zero_in, // store-and-zero pin
  input wire logic [15:0] i_pulse_count, // same-clock capture logic
  input wire pt_quad_t i_chan_pulse, // same-clock capture logic
  input wire pt_apb_req_t i_apb,
  output pt_apb_rsp_t o_apb,
  output logic o_pulse_fetch,
  output logic o_run_ok_out,
  output logic o_flow_limit_flag,
  output logic [15:0] o_running_sum_low,
  output logic [15:0] o_running_sum_high,
  output logic [15:0] o_saved_low,
  output logic [15:0] o_saved_high,
  output logic [15:0] o_window_count,
  output logic [3:0] o_channel_limit_flag,
  output logic o_irq
);
  // the divider counter is 16 bits wide and needs at least two states
  if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin : g_bad_tick
    $error("tick divider out of range");
  end

  typedef struct packed {
    logic [15:0] tick_cnt; // divider toward the control-cycle tick
    logic run_s1; // synchronisers
    logic run_s2;
    logic clr_s1;
    logic clr_s2;
    logic clr_prev; // clear level seen at the previous control-cycle tick, executed or idle
    logic mode; // 1 binary, 0 decimal
    logic [15:0] upper_trip_level;
    logic [15:0] lower_trip_level;
    logic [15:0] measuring_window; // in control cycles
    logic [15:0] time_sum_scratch;
    logic [31:0] pulse_sum_scratch;
    logic [15:0] sum_low;
    logic [15:0] sum_high;
    logic [15:0] saved_low;
    logic [15:0] saved_high;
    logic [15:0] window_count;
    logic flag;
    pt_quad_t ch_low;
    pt_quad_t ch_high;
    pt_quad_t ch_saved_low;
    pt_quad_t ch_saved_high;
    logic [3:0][31:0] ch_pulse_sum;
    pt_quad_t ch_flow; // engineering units
    pt_quad_t ch_upper;
    pt_quad_t ch_lower;
    pt_quad_t ch_factor;
    logic [3:0] ch_flag;
    logic [PT_IRQ_W-1:0] irq_stat;
    logic [PT_IRQ_W-1:0] irq_mask;
    logic irq;
    logic fetch;
    logic run_ok;
    logic [15:0] out_low; // visible copies, zero while not running
    logic [15:0] out_high;
    logic [15:0] out_saved_low;
    logic [15:0] out_saved_high;
    logic [15:0] out_window;
    logic out_flag;
    logic [3:0] out_ch_flag;
    pt_apb_rsp_t rsp;
  } pt_state_t;

  pt_state_t st;
  pt_state_t next_st;
  logic [4:0][15:0] wr_low; // wrap adders: index 4 single, 0..3 channels
  logic [4:0][15:0] wr_high;
  logic [4:0][15:0] wr_add;
  logic [4:0][15:0] res_low;
  logic [4:0][15:0] res_high;
  logic tick;

  // saturate a window total into a 16-bit word
  function automatic logic [15:0] sat16(input logic [31:0] v);
    sat16 = (v > 32'h0000ffff) ? 16'hffff : v[15:0];
  endfunction

  // scale a window total into engineering units, clamped to the span
  function automatic logic [15:0] scale_eu(input logic [31:0] cnt, input logic [15:0] f);
    logic [47:0] prod;
    logic [47:0] eu;
    prod = 48'(cnt) * 48'(f);
    eu = prod >> PT_FACTOR_FRAC;
    scale_eu = (eu > 48'(PT_EU_SPAN)) ? PT_EU_SPAN : eu[15:0];
  endfunction

  // hysteresis: set at/above (or strictly above) upper, clear at/below lower
  function automatic logic hyst(input logic cur, input logic [15:0] v, input logic [15:0] on,
                                input logic [15:0] off, input logic strict);
    if (strict ? (v > on) : (v >= on)) begin
      hyst = 1'b1;
    end else if (v <= off) begin
      hyst = 1'b0;
    end else begin
      hyst = cur;
    end
  endfunction

  assign wr_low = {st.sum_low, st.ch_low};
  assign wr_high = {st.sum_high, st.ch_high};
  assign wr_add = {i_pulse_count, i_chan_pulse};

  // five wrap adders share the one mode bit, saved words follow the same mode
  for (genvar g = 0; g < 5; g++) begin : g_wrap
    pt_wrap_add u_wrap (
      .i_low(wr_low[g]),
      .i_high(wr_high[g]),
      .i_add(wr_add[g]),
      .i_binary(st.mode),
      .o_low(res_low[g]),
      .o_high(res_high[g])
    );
  end

  assign tick = (st.tick_cnt == 16'(TICK_CYCLES - 1));

  // next-state logic: control cycle, window, channels, bus and interrupt
  always_comb begin
    logic [PT_IRQ_W-1:0] ev;
    logic [31:0] wsum;
    logic [31:0] csum;
    logic win_end;
    logic rise;
    logic [2:0] ci;
    logic [31:0] rd;
    logic err;
    ev = '0;
    wsum = '0;
    csum = '0;
    win_end = 1'b0;
    rise = 1'b0;
    ci = '0;
    rd = '0;
    err = 1'b0;
    next_st = st;
    next_st.run_s1 = i_run;
    next_st.run_s2 = st.run_s1;
    next_st.clr_s1 = i_store_and_zero_in;
    next_st.clr_s2 = st.clr_s1;
    next_st.fetch = 1'b0;
    next_st.tick_cnt = tick ? 16'h0000 : st.tick_cnt + 16'h0001;

    if (tick) begin
      // the capture side clears its local count on this strobe
      next_st.fetch = 1'b1;
      if (!st.run_s2) begin
        // idle cycle: totals are kept inside but every output except the fetch strobe, irq and apb reads zero
        next_st.run_ok = 1'b0;
        next_st.out_low = '0;
        next_st.out_high = '0;
        next_st.out_saved_low = '0;
        next_st.out_saved_high = '0;
        next_st.out_window = '0;
        next_st.out_flag = 1'b0;
        next_st.out_ch_flag = '0;
      end else begin
        // single totalizer: level store-and-zero wins over this cycle's pulses
        if (st.clr_s2) begin
          next_st.saved_low = st.sum_low;
          next_st.saved_high = st.sum_high;
          next_st.sum_low = '0;
          next_st.sum_high = '0;
          ev[PT_IRQ_STORE] = 1'b1;
        end else begin
          next_st.sum_low = res_low[4];
          next_st.sum_high = res_high[4];
        end
        // channels save on the rising edge only, then keep totalizing
        rise = st.clr_s2 && !st.clr_prev;
        for (int c = 0; c < 4; c++) begin
          if (rise) begin
            next_st.ch_saved_low[c] = st.ch_low[c];
            next_st.ch_saved_high[c] = st.ch_high[c];
            next_st.ch_low[c] = '0;
            next_st.ch_high[c] = '0;
          end else begin
            next_st.ch_low[c] = res_low[c];
            next_st.ch_high[c] = res_high[c];
          end
        end
        // measuring window: count cycles and pulses, publish at its end
        wsum = st.pulse_sum_scratch + 32'(i_pulse_count);
        win_end = (st.time_sum_scratch + 16'h0001) >= st.measuring_window;
        if (win_end) begin
          next_st.window_count = sat16(wsum);
          next_st.flag = hyst(st.flag, sat16(wsum), st.upper_trip_level,
                              st.lower_trip_level, 1'b0);
          next_st.pulse_sum_scratch = '0;
          next_st.time_sum_scratch = '0;
          ev[PT_IRQ_WIN] = 1'b1;
          ev[PT_IRQ_FLAG] = next_st.flag && !st.flag;
        end else begin
          next_st.pulse_sum_scratch = wsum;
          next_st.time_sum_scratch = st.time_sum_scratch + 16'h0001;
        end
        for (int c = 0; c < 4; c++) begin
          csum = st.ch_pulse_sum[c] + 32'(i_chan_pulse[c]);
          if (win_end) begin
            next_st.ch_flow[c] = scale_eu(csum, st.ch_factor[c]);
            next_st.ch_flag[c] = hyst(st.ch_flag[c], sat16(csum), st.ch_upper[c],
                                      st.ch_lower[c], 1'b1);
            next_st.ch_pulse_sum[c] = '0;
          end else begin
            next_st.ch_pulse_sum[c] = csum;
          end
        end
        next_st.run_ok = 1'b1;
        next_st.out_low = next_st.sum_low;
        next_st.out_high = next_st.sum_high;
        next_st.out_saved_low = next_st.saved_low;
        next_st.out_saved_high = next_st.saved_high;
        next_st.out_window = next_st.window_count;
        next_st.out_flag = next_st.flag;
        next_st.out_ch_flag = next_st.ch_flag;
      end
      next_st.clr_prev = st.clr_s2;
    end

    // apb: decode in the setup cycle, answer ready in the access cycle
    next_st.rsp.pready = 1'b0;
    next_st.rsp.pslverr = 1'b0;
    ci = {1'b0, i_apb.paddr[3:2]};
    if (i_apb.paddr == PT_OFF_CSW) begin
      rd[PT_CSW_RUN] = st.run_s2;
      rd[PT_CSW_CLR] = st.clr_s2;
      rd[PT_CSW_OK] = st.run_ok;
      rd[PT_CSW_FLAG] = st.flag;
      rd[PT_CSW_MODE] = st.mode;
    end else if (i_apb.paddr == PT_OFF_UPPER) begin
      rd = {16'h0000, st.upper_trip_level};
    end else if (i_apb.paddr == PT_OFF_LOWER) begin
      rd = {16'h0000, st.lower_trip_level};
    end else if (i_apb.paddr == PT_OFF_WINDOW) begin
      rd = {16'h0000, st.measuring_window};
    end else if (i_apb.paddr == PT_OFF_SUM) begin
      rd = {st.sum_high, st.sum_low};
    end else if (i_apb.paddr == PT_OFF_SAVED) begin
      rd = {st.saved_high, st.saved_low};
    end else if (i_apb.paddr == PT_OFF_WCOUNT) begin
      rd = {16'h0000, st.window_count};
    end else if (i_apb.paddr == PT_OFF_IRQ_STAT) begin
      rd = 32'(st.irq_stat);
    end else if (i_apb.paddr == PT_OFF_IRQ_MASK) begin
      rd = 32'(st.irq_mask);
    end else if (i_apb.paddr[11:4] == PT_OFF_CH_TRIP[11:4] && i_apb.paddr[1:0] == 2'b00) begin
      rd = {st.ch_lower[ci[1:0]], st.ch_upper[ci[1:0]]};
    end else if (i_apb.paddr[11:4] == PT_OFF_CH_FACTOR[11:4] && i_apb.paddr[1:0] == 2'b00) begin
      rd = {16'h0000, st.ch_factor[ci[1:0]]};
    end else if (i_apb.paddr[11:4] == PT_OFF_CH_FLOW[11:4] && i_apb.paddr[1:0] == 2'b00) begin
      rd = {15'h0000, st.ch_flag[ci[1:0]], st.ch_flow[ci[1:0]]};
    end else if (i_apb.paddr[11:4] == PT_OFF_CH_SUM[11:4] && i_apb.paddr[1:0] == 2'b00) begin
      rd = {st.ch_high[ci[1:0]], st.ch_low[ci[1:0]]};
    end else if (i_apb.paddr[11:4] == PT_OFF_CH_SAVED[11:4] && i_apb.paddr[1:0] == 2'b00) begin
      rd = {st.ch_saved_high[ci[1:0]], st.ch_saved_low[ci[1:0]]};
    end else begin
      err = 1'b1; // unmapped: error answer, data zero
    end
    if (i_apb.psel && !i_apb.penable) begin
      next_st.rsp.pready = 1'b1;
      next_st.rsp.pslverr = err;
      next_st.rsp.prdata = (err || i_apb.pwrite) ? 32'h0000_0000 : rd;
    end

    // interrupt status: a read clears, but a same-cycle event still sets
    next_st.irq_stat = st.irq_stat;
    if (i_apb.psel && i_apb.penable && st.rsp.pready && !st.rsp.pslverr) begin
      if (!i_apb.pwrite && i_apb.paddr == PT_OFF_IRQ_STAT) begin
        next_st.irq_stat = '0;
      end else if (i_apb.pwrite) begin
        if (i_apb.paddr == PT_OFF_CSW) begin
          next_st.mode = i_apb.pwdata[PT_CSW_MODE];
        end else if (i_apb.paddr == PT_OFF_UPPER) begin
          next_st.upper_trip_level = i_apb.pwdata[15:0];
        end else if (i_apb.paddr == PT_OFF_LOWER) begin
          next_st.lower_trip_level = i_apb.pwdata[15:0];
        end else if (i_apb.paddr == PT_OFF_WINDOW) begin
          // a zero window would end every control cycle anyway; store it as one cycle
          next_st.measuring_window = (i_apb.pwdata[15:0] == 16'h0000) ? 16'h0001
                                                                        : i_apb.pwdata[15:0];
        end else if (i_apb.paddr == PT_OFF_IRQ_MASK) begin
          next_st.irq_mask = i_apb.pwdata[PT_IRQ_W-1:0];
        end else if (i_apb.paddr[11:4] == PT_OFF_CH_TRIP[11:4]) begin
          next_st.ch_upper[ci[1:0]] = i_apb.pwdata[15:0];
          next_st.ch_lower[ci[1:0]] = i_apb.pwdata[31:16];
        end else if (i_apb.paddr[11:4] == PT_OFF_CH_FACTOR[11:4]) begin
          next_st.ch_factor[ci[1:0]] = i_apb.pwdata[15:0];
        end
      end
    end
    next_st.irq_stat = next_st.irq_stat | ev;
    next_st.irq = |(next_st.irq_stat & next_st.irq_mask);
  end

  // one register for the whole state; reset loads constants only
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st <= '0;
      st.mode <= PT_MODE_RST;
      st.upper_trip_level <= PT_TRIP_RST;
      st.lower_trip_level <= PT_TRIP_RST;
      st.measuring_window <= PT_WINDOW_RST;
      st.ch_upper <= {4{PT_TRIP_RST}};
      st.ch_lower <= {4{PT_TRIP_RST}};
      st.ch_factor <= {4{PT_FACTOR_ONE}};
    end else begin
      st <= next_st;
    end
  end

  assign o_apb = st.rsp;
  assign o_pulse_fetch = st.fetch;
  assign o_run_ok_out = st.run_ok;
  assign o_flow_limit_flag = st.out_flag;
  assign o_running_sum_low = st.out_low;
  assign o_running_sum_high = st.out_high;
  assign o_saved_low = st.out_saved_low;
  assign o_saved_high = st.out_saved_high;
  assign o_window_count = st.out_window;
  assign o_channel_limit_flag = st.out_ch_flag;
  assign o_irq = st.irq;

  logic win_end_w; // window end seen by the flag assertion
  assign win_end_w = (st.time_sum_scratch + 16'h0001) >= st.measuring_window;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_sys_rst);

  sequence run_tick_s;
    tick && st.run_s2;
  endsequence

  fetch_strobe_a: assert property (tick |=> o_pulse_fetch ##1 !o_pulse_fetch)
    else $error("fetch strobe not one cycle after tick");
  idle_zero_a: assert property ((tick && !st.run_s2) |=> !o_run_ok_out && o_running_sum_low == 0
                                && o_window_count == 0)
    else $error("outputs not zero while idle");
  run_ok_a: assert property (run_tick_s |=> o_run_ok_out)
    else $error("run ok missing after execution");
  store_zero_a: assert property ((run_tick_s and st.clr_s2) |=> st.sum_low == 0
                                 && st.sum_high == 0 && st.saved_low == $past(st.sum_low))
    else $error("store and zero wrong");
  add_pulses_a: assert property ((run_tick_s and !st.clr_s2) |=> st.sum_low == $past(res_low[4])
                                 && st.sum_high >= $past(st.sum_high))
    else $error("pulses not added");
  bin_wrap_a: assert property ((run_tick_s and st.mode && !st.clr_s2) |=> st.sum_low < 16'h8000
                               && ({1'b0, st.sum_high} * 17'h08000 + st.sum_low
                               == {1'b0, $past(st.sum_high)} * 17'h08000 + $past(st.sum_low)
                               + $past(i_pulse_count)))
    else $error("binary wrap wrong");
  dec_wrap_a: assert property ((run_tick_s and !st.mode && !st.clr_s2 && st.sum_low < 16'h2710)
                               |=> st.sum_low < 16'h2710)
    else $error("decimal wrap wrong");
  flag_set_a: assert property ((run_tick_s and win_end_w && sat16(st.pulse_sum_scratch
                               + 32'(i_pulse_count)) >= st.upper_trip_level) |=> st.flag)
    else $error("flow flag not set");
  chan_edge_a: assert property ((run_tick_s and st.clr_s2 && !st.clr_prev) |=> st.ch_low == '0
                                && st.ch_saved_low == $past(st.ch_low))
    else $error("channel save on edge wrong");
endmodule

// *** sim/pt_capture_model.sv ***
`timescale 1ns/1ps
// stand-in for the pulse-capture hardware that feeds the totalizer
module pt_capture_model
  import pt_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_fetch, // reader has taken this cycle's count
  input wire logic i_stb, // new pulses arrive this cycle
  input wire logic [15:0] i_add,
  input wire pt_quad_t i_add_ch,
  output logic [15:0] o_count,
  output pt_quad_t o_chan
);
  // local count, restarted by every fetch so it never overflows;
  // pulses landing in the fetch cycle belong to the next control cycle
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_count <= 16'h0000;
      o_chan <= '0;
    end else if (i_fetch) begin
      o_count <= i_stb ? i_add : 16'h0000;
      o_chan <= i_stb ? i_add_ch : '0;
    end else if (i_stb) begin
      o_count <= o_count + i_add;
      for (int n = 0; n < 4; n++) begin
        o_chan[n] <= o_chan[n] + i_add_ch[n];
      end
    end
  end
endmodule

// *** sim/tb_pulse_totalizer.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_pulse_totalizer;
  import pt_pkg::*;
  localparam int TK = 4; // short control cycle keeps the run brief
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_run = 1'b1;
  logic i_store_and_zero_in = 1'b0;
  logic stb = 1'b0; // pulse injection into the capture model
  logic [15:0] add_p = 16'h0000;
  pt_quad_t add_c = '0;
  logic [15:0] cnt;
  pt_quad_t chan;
  pt_apb_req_t req = '0;
  pt_apb_rsp_t rsp;
  logic fetch, ok, flag, irq;
  logic [15:0] s_lo, s_hi, m_lo, m_hi, wcnt;
  logic [3:0] cflag;
  logic [31:0] rd;
  logic er;
  int err_total = 0;
  int n_tests = 0;
  // window pulses and the flag each should leave behind
  logic [15:0] wv [5] = '{16'd100, 16'd51, 16'd50, 16'd99, 16'd100};
  logic fv [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  logic [31:0] flow_exp [3] = '{32'h00012710, 32'h0001003c, 32'h0000000a};
  int i;

  pt_pulse_totalizer #(.TICK_CYCLES(TK)) dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_run(i_run), .i_store_and_zero_in(i_store_and_zero_in), .i_pulse_count(cnt),
    .i_chan_pulse(chan), .i_apb(req), .o_apb(rsp), .o_pulse_fetch(fetch),
    .o_run_ok_out(ok), .o_flow_limit_flag(flag), .o_running_sum_low(s_lo),
    .o_running_sum_high(s_hi), .o_saved_low(m_lo), .o_saved_high(m_hi),
    .o_window_count(wcnt), .o_channel_limit_flag(cflag), .o_irq(irq));

  pt_capture_model cap (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_fetch(fetch),
    .i_stb(stb), .i_add(add_p), .i_add_ch(add_c), .o_count(cnt), .o_chan(chan));

  // free-running 250 MHz clock
  initial begin
    forever #2 i_clk = ~i_clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // one apb transfer; an idle cycle first so req is never driven twice at one edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge i_clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge i_clk);
    req.penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge i_clk);
      if (rsp.pready === 1'b1) break;
    end
    if (k == 20) begin
      err_total++;
      tally_and_finish();
    end
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
  endtask

  // returns at the edge where the capture side sees the fetch pulse
  task automatic wait_fetch();
    int k;
    for (k = 0; k < 20; k++) begin
      @(posedge i_clk);
      if (fetch === 1'b1) break;
    end
    if (k == 20) begin
      err_total++;
      tally_and_finish();
    end
  endtask

  // one control cycle of pulses; called right at a fetch edge
  task automatic cyc(input logic [15:0] p, input pt_quad_t c);
    stb <= 1'b1;
    add_p <= p;
    add_c <= c;
    @(posedge i_clk);
    stb <= 1'b0;
    wait_fetch();
  endtask

  // pin held one control cycle long, so exactly one tick sees it
  task automatic store();
    i_store_and_zero_in <= 1'b1;
    repeat (TK) @(posedge i_clk);
    i_store_and_zero_in <= 1'b0;
    wait_fetch();
  endtask

  initial begin
    repeat (2) @(posedge i_clk);
    `CHK({s_lo, s_hi, m_lo, m_hi, wcnt, ok, flag, cflag, irq}, 87'h0)
    i_sys_rst <= 1'b0;
    apb(1'b0, PT_OFF_CSW, 32'h0);
    `CHK(rd[PT_CSW_MODE], PT_MODE_RST)
    apb(1'b0, PT_OFF_WINDOW, 32'h0);
    `CHK(rd, {16'h0000, PT_WINDOW_RST})
    apb(1'b0, PT_OFF_CH_FACTOR, 32'h0);
    `CHK(rd, {16'h0000, PT_FACTOR_ONE})
    apb(1'b0, 12'h0fc, 32'h0); // unmapped place
    `CHK({er, rd}, 33'h100000000)
    $display("test reset done");
    // binary wrap: 32000 + 800 crosses 32768 once
    wait_fetch();
    cyc(16'd32000, '0);
    cyc(16'd800, '0);
    `CHK({s_hi, s_lo}, 32'h00010020)
    apb(1'b0, PT_OFF_SUM, 32'h0);
    `CHK(rd, 32'h00010020)
    wait_fetch();
    store();
    `CHK({m_hi, m_lo, s_hi, s_lo}, 64'h0001002000000000)
    // decimal wrap: 9999 + 2 crosses 10000 once
    apb(1'b1, PT_OFF_CSW, 32'h0);
    wait_fetch();
    cyc(16'd9999, '0);
    cyc(16'd2, '0);
    `CHK({s_hi, s_lo}, 32'h00010001)
    store();
    `CHK({m_hi, m_lo, s_hi, s_lo}, 64'h0001000100000000)
    $display("test totals done");
    // hysteresis walk across both trip levels, interrupt on flag rise
    apb(1'b1, PT_OFF_UPPER, 32'd100);
    apb(1'b1, PT_OFF_LOWER, 32'd50);
    apb(1'b1, PT_OFF_IRQ_MASK, 32'h2);
    apb(1'b0, PT_OFF_IRQ_STAT, 32'h0);
    wait_fetch();
    for (i = 0; i < 5; i++) begin
      cyc(wv[i], '0);
      `CHK({wcnt, flag}, {wv[i], fv[i]})
    end
    apb(1'b0, PT_OFF_CSW, 32'h0);
    `CHK(rd[3:0], 4'hd)
    `CHK(irq, 1'b1)
    apb(1'b0, PT_OFF_IRQ_STAT, 32'h0);
    `CHK(rd[PT_IRQ_FLAG], 1'b1)
    repeat (2) @(posedge i_clk);
    `CHK(irq, 1'b0)
    // a masked rise stays pending and shows once unmasked
    apb(1'b1, PT_OFF_IRQ_MASK, 32'h0);
    wait_fetch();
    cyc(16'd100, '0);
    repeat (2) @(posedge i_clk);
    `CHK(irq, 1'b0)
    apb(1'b1, PT_OFF_IRQ_MASK, 32'h2);
    repeat (2) @(posedge i_clk);
    `CHK(irq, 1'b1)
    $display("test window done");
    // channels: clamp at unity factor, double factor, strict upper trip
    apb(1'b1, PT_OFF_CH_FACTOR + 12'h004, 32'h200);
    apb(1'b1, PT_OFF_CH_TRIP + 12'h008, 32'h0005000a);
    wait_fetch();
    for (i = 0; i < 3; i++) begin
      cyc(16'h0, {16'd0, 16'd10, 16'd30, 16'd20000});
      apb(1'b0, PT_OFF_CH_FLOW + 12'(4 * i), 32'h0);
      `CHK(rd, flow_exp[i])
      wait_fetch();
    end
    `CHK(cflag, 4'b0000)
    cyc(16'h0, {16'd0, 16'd11, 16'd0, 16'd0});
    `CHK(cflag, 4'b0100)
    apb(1'b0, PT_OFF_CH_SUM + 12'h004, 32'h0);
    `CHK(rd, 32'h0000005a)
    wait_fetch();
    store();
    apb(1'b0, PT_OFF_CH_SAVED + 12'h004, 32'h0);
    `CHK(rd, 32'h0000005a)
    apb(1'b0, PT_OFF_CH_SUM + 12'h004, 32'h0);
    `CHK(rd, 32'h00000000)
    $display("test channels done");
    // run withdrawn: nothing executes and the ok, flag, total, saved and window outputs read zero
    i_run <= 1'b0;
    repeat (4 * TK) @(posedge i_clk);
    `CHK({ok, flag, s_lo, s_hi, m_lo, m_hi, wcnt, cflag}, 86'h0)
    i_run <= 1'b1;
    wait_fetch();
    wait_fetch();
    `CHK(ok, 1'b1)
    $display("test run done");
    tally_and_finish();
  end
endmodule
